// file: src/ptbc_defines.svh
`ifndef PTBC_DEFINES_SVH
`define PTBC_DEFINES_SVH

// ****************************************************************
// Register map and field positions
// ****************************************************************

// Timer t (0..3) owns three words: control at 3t, period at 3t+1, count at 3t+2.
`define PTBC_OFS_CTRL    0
`define PTBC_OFS_PERIOD  1
`define PTBC_OFS_COUNT   2
`define PTBC_REG_STRIDE  3
// Shared interrupt registers.
`define PTBC_REG_FLAG    4'hc
`define PTBC_REG_ENABLE  4'hd
`define PTBC_REG_PRIO    4'he

// Control register bit positions.
`define PTBC_RUN_BIT     15
`define PTBC_IDLE_BIT    13
`define PTBC_GATE_BIT    6
`define PTBC_PS_HI       5
`define PTBC_PS_LO       4
`define PTBC_JOIN_BIT    3
`define PTBC_CS_BIT      1

// Writable bits of the control registers; the rest read as zero.
`define PTBC_CTRL_MASK_B 16'ha07a
`define PTBC_CTRL_MASK_C 16'ha072

// Reset values.
`define PTBC_CTRL_RST    16'h0000
`define PTBC_PERIOD_RST  16'hffff
`define PTBC_COUNT_RST   16'h0000

// Prescaler terminal counts for divide by 1, 8, 64 and 256.
`define PTBC_PS_LIM_1    8'h00
`define PTBC_PS_LIM_8    8'h07
`define PTBC_PS_LIM_64   8'h3f
`define PTBC_PS_LIM_256  8'hff

`endif

// file: src/ptbc_pkg.sv
// ****************************************************************
// Types shared by the paired timer
// ****************************************************************
package ptbc_pkg;

   // Register word index on the software port.
   typedef logic [3:0] ptbc_addr_t;

   // Prescale select codes.
   typedef enum logic [1:0]
   {
      PTBC_PS_1   = 2'h0,
      PTBC_PS_8   = 2'h1,
      PTBC_PS_64  = 2'h2,
      PTBC_PS_256 = 2'h3
   } ptbc_prescale_t;

endpackage : ptbc_pkg

// file: src/ptbc_timer.sv
// Summary of operation
// R1: Timers 0/1 and 2/3 join into 32-bit pairs.
// R2: Type B pin synchronised after its prescaler.
// R3: Type C pin synchronised before its prescaler.
// R4: Type C timers give an ADC trigger.
// R5: Internal clock for timer/gated, pin for counter.
// R6: Clock source select at control bit 1.
// R7: Gate enable at control bit 6.
// R8: Only first pair gives DMA triggers.
// R9: Join bit 3 of Type B enables 32-bit.
// R10: C count is high word, carry from B.
// R11: Joined pair uses Type B settings, C idle-stop.
// R12: Joined pair interrupts through Type C controls.
// R13: Joined period is C high, B low.
// R14: Software sets up a 16-bit timer in order.
// R15: Software sets up a 32-bit pair in order.
// R16: Joined count reads as C high, B low.
// R17: Prescale codes divide by 1, 8, 64, 256.
// R18: Run bit starts/stops; Type B runs pair.
// R19: Idle-stop bit halts timer in Idle.
// R20: Joined pair idles only by Type C bit.
// R21: Period match clears count and sets flag.
// R22: Gated mode counts while high, flags on fall.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`include "ptbc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module ptbc_timer
#(
   parameter int CNT_W = 16 // Width of one timer word.
)
(
   input  wire  logic                clock,                // System clock, 100 MHz.
   input  wire  logic                rst,                  // Synchronous reset, active high.
   input  wire  logic [3:0]          addr,                 // Register word index.
   input  wire  logic [15:0]         wdata,                // Write data.
   input  wire  logic                wr,                   // Write strobe.
   input  wire  logic                rd,                   // Read strobe.
   output var   logic [15:0]         rdata_ff,             // Read data, cycle after rd.
   input  wire  logic                idle_mode,            // Device is in Idle.
   input  wire  logic [3:0]          ext_timer_clock_pin,  // Pin clock or gate per timer.
   output var   logic [3:0]          irq_ff,               // Interrupt request per timer.
   output var   logic [1:0]          adc_trig_ff,          // Conversion trigger per pair.
   output var   logic [1:0]          dma_trig_ff           // Transfer trigger, first pair.
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************

   // The register map and compare logic are laid out for 16-bit words.
   if (CNT_W != 16)
   begin : g_chk
      $error("ptbc_timer supports CNT_W of 16 only.");
   end

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Word index of register k of timer t.
   function automatic ptbc_pkg::ptbc_addr_t reg_addr(input int t, input int k);
      reg_addr = ptbc_pkg::ptbc_addr_t'(`PTBC_REG_STRIDE * t + k);
   endfunction : reg_addr

   // Terminal count of the prescaler for a select code.
   function automatic logic [7:0] ps_limit(input logic [1:0] code);
      case (ptbc_pkg::ptbc_prescale_t'(code))
         ptbc_pkg::PTBC_PS_1:   ps_limit = `PTBC_PS_LIM_1;
         ptbc_pkg::PTBC_PS_8:   ps_limit = `PTBC_PS_LIM_8;
         ptbc_pkg::PTBC_PS_64:  ps_limit = `PTBC_PS_LIM_64;
         default:               ps_limit = `PTBC_PS_LIM_256;
      endcase
   endfunction : ps_limit

   // ****************************************************************
   // Storage
   // ****************************************************************

   logic [15:0] ctrl_ff   [4];   // Control registers.
   logic [15:0] period_ff [4];   // Period registers.
   logic [15:0] count_ff  [4];   // Count registers.
   logic [15:0] nxt_count [4];   // Next value of the counts.
   logic [3:0]  flag_ff;         // Sticky interrupt flags.
   logic [3:0]  ien_ff;          // Interrupt enables.
   logic [11:0] prio_ff;         // Three priority bits per timer.
   logic [3:0]  pin_meta_ff;     // First synchroniser stage.
   logic [3:0]  pin_sync_ff;     // Second synchroniser stage.
   logic [3:0]  pin_prev_ff;     // Delayed copy for edge detection.
   logic [7:0]  ps_cnt_ff [4];   // Prescaler counters.
   logic [3:0]  btick_ff;        // Retimed prescaler output of Type B.
   logic [3:0]  active_w;        // Timer is running.
   logic [3:0]  gated_w;         // Timer is in gated mode.
   logic [3:0]  hit_w;           // Prescaler terminal count reached.
   logic [3:0]  src_w;           // Prescaler input strobe per timer.
   logic [3:0]  tick_w;          // Count advance strobe.
   logic [3:0]  fall_w;          // Gate fell while gated.
   logic [3:0]  cs_w;            // Effective clock source select.
   logic [3:0]  evt_w;           // Interrupt event per timer.
   logic [1:0]  join_w;          // Pair joined to 32 bits.
   logic [15:0] nxt_rdata;       // Read data before the register.

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   // Two flip-flops before any logic sees a pin.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pin_meta_ff <= 4'h0;
         pin_sync_ff <= 4'h0;
         pin_prev_ff <= 4'h0;
      end
      else
      begin
         pin_meta_ff <= ext_timer_clock_pin;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   // ****************************************************************
   // Per-timer clock selection and prescaler
   // ****************************************************************

   for (genvar p = 0; p < 2; p++)
   begin : g_pair
      // Joining is steered only by the Type B control word.
      assign join_w[p] = ctrl_ff[2*p][`PTBC_JOIN_BIT]; // R9
   end

   for (genvar i = 0; i < 4; i++)
   begin : g_tmr
      localparam int B   = i - (i % 2);
      localparam bit IsC = (i % 2) == 1;
      logic        joined;   // This timer belongs to a joined pair.
      logic [15:0] ectl;     // Control word in force.
      logic        istop;    // Idle-stop bit in force.
      logic        psel;     // Selected synchronised pin.
      logic        pfell;    // Selected pin fell.
      logic        prise;    // Selected pin rose.

      assign joined = join_w[i/2];
      // A joined Type C timer takes its settings from its Type B partner.
      assign ectl   = (IsC && joined) ? ctrl_ff[B] : ctrl_ff[i]; // R11
      // A joined pair stops in Idle only by the Type C bit.
      assign istop  = ctrl_ff[joined ? B+1 : i][`PTBC_IDLE_BIT]; // R19 R20
      assign psel   = (IsC && joined) ? pin_sync_ff[B] : pin_sync_ff[i];
      assign prise  = psel & ~((IsC && joined) ? pin_prev_ff[B] : pin_prev_ff[i]);
      assign pfell  = ~psel & ((IsC && joined) ? pin_prev_ff[B] : pin_prev_ff[i]);
      // Run bit starts and stops; Idle halts only when idle-stop is set.
      assign active_w[i] = ectl[`PTBC_RUN_BIT] & ~(idle_mode & istop); // R18 R19
      assign cs_w[i]     = ectl[`PTBC_CS_BIT]; // R6
      // Gate enable matters only with the internal clock.
      assign gated_w[i]  = ~ectl[`PTBC_CS_BIT] & ectl[`PTBC_GATE_BIT]; // R7
      // Pin edges in counter mode, instruction clock otherwise, held while gate low.
      assign src_w[i] = ectl[`PTBC_CS_BIT] ? prise : (gated_w[i] ? psel : 1'b1); // R5 R22
      assign hit_w[i]  = active_w[i] & src_w[i]
                         & (ps_cnt_ff[i] == ps_limit(ectl[`PTBC_PS_HI:`PTBC_PS_LO])); // R17
      assign fall_w[i] = active_w[i] & gated_w[i] & pfell; // R22
      // Type C synchronises the pin ahead of the prescaler, so its output is used directly;
      // Type B in counter mode retimes the prescaler output through one more stage.
      assign tick_w[i] = (!IsC && ectl[`PTBC_CS_BIT]) ? btick_ff[i] : hit_w[i]; // R2 R3
   end

   // Prescaler counters clear while the timer is stopped and at terminal count.
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (rst || !active_w[i] || hit_w[i])
            ps_cnt_ff[i] <= 8'h00;
         else if (src_w[i])
            ps_cnt_ff[i] <= ps_cnt_ff[i] + 8'h01; // R17
      end
   end

   // Post-prescaler synchronising stage of the Type B timers.
   always_ff @(posedge clock)
   begin
      if (rst)
         btick_ff <= 4'h0;
      else
         btick_ff <= hit_w & active_w & cs_w; // R2
   end

   // ****************************************************************
   // Count, period compare and events
   // ****************************************************************

   // Next counts and events for both pairs, independent or joined.
   always_comb
   begin
      logic [31:0] full_v;
      logic [31:0] per_v;
      full_v = 32'h0;
      per_v  = 32'h0;
      evt_w  = 4'h0;
      for (int i = 0; i < 4; i++)
         nxt_count[i] = count_ff[i];
      for (int p = 0; p < 2; p++)
      begin
         full_v = {count_ff[2*p+1], count_ff[2*p]};  // R10 R16
         per_v  = {period_ff[2*p+1], period_ff[2*p]}; // R13
         if (join_w[p])
         begin
            // Low word carries into the high word; all 32 bits compare at once.
            if (tick_w[2*p])
            begin
               if (full_v == per_v) // R21
                  {nxt_count[2*p+1], nxt_count[2*p]} = 32'h0;
               else
                  {nxt_count[2*p+1], nxt_count[2*p]} = full_v + 32'h1; // R10
            end
            // The joined event lands on the Type C flag only.
            evt_w[2*p+1] = (tick_w[2*p] & (full_v == per_v) & ~gated_w[2*p]) | fall_w[2*p]; // R12
         end
         else
         begin
            for (int k = 0; k < 2; k++)
            begin
               if (tick_w[2*p+k])
               begin
                  if (count_ff[2*p+k] == period_ff[2*p+k]) // R21
                     nxt_count[2*p+k] = 16'h0000;
                  else
                     nxt_count[2*p+k] = count_ff[2*p+k] + 16'h0001;
               end
               evt_w[2*p+k] = (tick_w[2*p+k] & (count_ff[2*p+k] == period_ff[2*p+k])
                               & ~gated_w[2*p+k]) | fall_w[2*p+k]; // R21 R22
            end
         end
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************

   // Control, period and count words; a software write to a count wins over counting.
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (rst)
         begin
            ctrl_ff[i]   <= `PTBC_CTRL_RST;
            period_ff[i] <= `PTBC_PERIOD_RST;
            count_ff[i]  <= `PTBC_COUNT_RST;
         end
         else
         begin
            if (wr && addr == reg_addr(i, `PTBC_OFS_CTRL))
               // Only Type B words keep the join bit.
               ctrl_ff[i] <= wdata
                             & (((i % 2) == 0) ? `PTBC_CTRL_MASK_B : `PTBC_CTRL_MASK_C); // R1 R9
            if (wr && addr == reg_addr(i, `PTBC_OFS_PERIOD))
               period_ff[i] <= wdata;
            if (wr && addr == reg_addr(i, `PTBC_OFS_COUNT))
               count_ff[i] <= wdata;
            else
               count_ff[i] <= nxt_count[i];
         end
      end
   end

   // Interrupt flags: a hardware event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         flag_ff <= 4'h0;
         ien_ff  <= 4'h0;
         prio_ff <= 12'h000;
      end
      else
      begin
         flag_ff <= evt_w | (flag_ff & ~((wr && addr == `PTBC_REG_FLAG) ? wdata[3:0] : 4'h0)); // R21
         if (wr && addr == `PTBC_REG_ENABLE)
            ien_ff <= wdata[3:0];
         if (wr && addr == `PTBC_REG_PRIO)
            prio_ff <= wdata[11:0];
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Requests; a joined Type B timer has its own interrupt controls ignored.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         irq_ff      <= 4'h0;
         adc_trig_ff <= 2'h0;
         dma_trig_ff <= 2'h0;
      end
      else
      begin
         irq_ff      <= flag_ff & ien_ff & ~{1'b0, join_w[1], 1'b0, join_w[0]}; // R12
         adc_trig_ff <= {evt_w[3], evt_w[1]}; // R4
         dma_trig_ff <= evt_w[1:0]; // R8
      end
   end

   // Read mux; unmapped words read as zero.
   always_comb
   begin
      nxt_rdata = 16'h0000;
      for (int i = 0; i < 4; i++)
      begin
         if (addr == reg_addr(i, `PTBC_OFS_CTRL))
            nxt_rdata = ctrl_ff[i];
         if (addr == reg_addr(i, `PTBC_OFS_PERIOD))
            nxt_rdata = period_ff[i];
         if (addr == reg_addr(i, `PTBC_OFS_COUNT))
            nxt_rdata = count_ff[i]; // R16
      end
      if (addr == `PTBC_REG_FLAG)
         nxt_rdata = {12'h000, flag_ff};
      if (addr == `PTBC_REG_ENABLE)
         nxt_rdata = {12'h000, ien_ff};
      if (addr == `PTBC_REG_PRIO)
         nxt_rdata = {4'h0, prio_ff};
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clock)
   begin
      if (rst || !rd)
         rdata_ff <= 16'h0000;
      else
         rdata_ff <= nxt_rdata;
   end

endmodule : ptbc_timer

`default_nettype wire

// file: testbench/ptbc_timer_props.sv
`include "ptbc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Port checker for the paired timer
// ****************************************************************
module ptbc_timer_props
(
   input  wire  logic        clock,               // System clock.
   input  wire  logic        rst,                 // Synchronous reset.
   input  wire  logic [3:0]  addr,                // Register index.
   input  wire  logic [15:0] wdata,               // Write data.
   input  wire  logic        wr,                  // Write strobe.
   input  wire  logic        rd,                  // Read strobe.
   input  wire  logic [15:0] rdata_ff,            // Read data.
   input  wire  logic        idle_mode,           // Device Idle.
   input  wire  logic [3:0]  ext_timer_clock_pin, // Timer pins.
   input  wire  logic [3:0]  irq_ff,              // Interrupt requests.
   input  wire  logic [1:0]  adc_trig_ff,         // Conversion triggers.
   input  wire  logic [1:0]  dma_trig_ff          // Transfer triggers.
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // A read strobe at one register index.
   sequence s_rd(logic [3:0] a);
      rd && addr == a;
   endsequence

   // A period write followed at once by a read of the same word.
   sequence s_per_echo;
      wr && addr == 4'h1 ##1 rd && addr == 4'h1;
   endsequence

   a_rdata_quiet: assert property (!rd |=> rdata_ff == 16'h0000)
      else $error("read data not zero outside an answer");
   a_unmapped_zero: assert property (s_rd(4'hf) |=> rdata_ff == 16'h0000)
      else $error("unmapped word did not read zero");
   a_mask_b: assert property ((s_rd(4'h0) or s_rd(4'h6)) |=>
      (rdata_ff & ~`PTBC_CTRL_MASK_B) == 16'h0000) else $error("Type B spare bits set");
   a_mask_c: assert property ((s_rd(4'h3) or s_rd(4'h9)) |=>
      (rdata_ff & ~`PTBC_CTRL_MASK_C) == 16'h0000) else $error("Type C spare bits set");
   a_prio_width: assert property (s_rd(`PTBC_REG_PRIO) |=> rdata_ff[15:12] == 4'h0)
      else $error("priority word wider than four fields");
   a_trig_tie: assert property (adc_trig_ff[0] == dma_trig_ff[1])
      else $error("first pair triggers disagree");
   a_period_echo: assert property (s_per_echo |=> rdata_ff == $past(wdata, 2))
      else $error("period word not read back");
   a_irq_fall: assert property ($fell(irq_ff[1]) |-> $past(wr, 2) &&
      $past(addr, 2) inside {`PTBC_REG_FLAG, `PTBC_REG_ENABLE}) else $error("irq fell unasked");
endmodule : ptbc_timer_props

bind ptbc_timer ptbc_timer_props ptbc_timer_props_inst (.clock(clock), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .idle_mode(idle_mode),
   .ext_timer_clock_pin(ext_timer_clock_pin), .irq_ff(irq_ff), .adc_trig_ff(adc_trig_ff),
   .dma_trig_ff(dma_trig_ff));

`default_nettype wire

// file: testbench/testbench.sv
`include "ptbc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

// ****************************************************************
// Self-checking bench for the paired timer
// ****************************************************************
module testbench;
   logic        clock = 1'b0;        // Bench clock.
   logic        rst = 1'b1;          // Reset, held at start.
   logic [3:0]  addr = 4'h0;         // Register index.
   logic [15:0] wdata = 16'h0000;    // Write data.
   logic        wr = 1'b0;           // Write strobe.
   logic        rd = 1'b0;           // Read strobe.
   logic        idle_mode = 1'b0;    // Device Idle.
   logic [3:0]  pins = 4'h0;         // Pin clocks or gates.
   logic [15:0] rdata_ff;            // Read answer.
   logic [3:0]  irq_ff;              // Interrupts.
   logic [1:0]  adc_trig_ff;         // Conversion triggers.
   logic [1:0]  dma_trig_ff;         // Transfer triggers.
   logic [15:0] exp_q[$];            // Expected read answers.
   logic [15:0] exp_v;               // Oldest expected answer.
   logic        p1 = 1'b0;           // A read was taken last edge.
   logic [31:0] seed = 32'h8a73;     // Random state.
   int          num_errors = 0;      // Mismatch count.
   int          checks = 0;          // Comparison count.
   int          adc_n[2] = '{0, 0};  // Conversion pulses seen.
   int          dma_n[2] = '{0, 0};  // Transfer pulses seen.
   int          dv[4] = '{1, 8, 64, 256}; // Prescale ratios.
   int          a0, d0, d1;          // Pulse counts before a run.
   logic [31:0] r;                   // Random word.

   always #5 clock = ~clock;

   ptbc_timer ptbc_timer_inst (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_ff(rdata_ff), .idle_mode(idle_mode), .ext_timer_clock_pin(pins),
      .irq_ff(irq_ff), .adc_trig_ff(adc_trig_ff), .dma_trig_ff(dma_trig_ff));

   // Compares each read answer in the cycle it stands and counts trigger pulses.
   always @(posedge clock)
   begin
      if (p1)
      begin
         exp_v = exp_q.pop_front();
         `CHK(rdata_ff, exp_v)
      end
      p1 <= rd;
      for (int i = 0; i < 2; i++)
      begin
         adc_n[i] += int'(adc_trig_ff[i]);
         dma_n[i] += int'(dma_trig_ff[i]);
      end
   end

   // Gives the next xorshift value.
   function logic [31:0] rand_next();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rand_next

   // Forms the index of word o of timer t.
   function logic [3:0] ra(input int t, input int o);
      return 4'(3 * t + o);
   endfunction : ra

   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc

   // One-cycle write.
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   // One-cycle read; the answer is noted for the monitor.
   task rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      rd <= 1'b0;
   endtask : rd_chk

   // Write followed with no gap by a read of the same word.
   task wr_rd(input logic [3:0] a, input logic [15:0] d);
      wr_reg(a, d);
      rd <= 1'b1;
      exp_q.push_back(d);
      @(posedge clock);
      rd <= 1'b0;
   endtask : wr_rd

   // Runs timer t from zero for n cycles with control c, then checks the count.
   task run_cnt(input int t, input logic [15:0] c, input int n, input logic [15:0] e);
      wr_reg(ra(t, 1), 16'hffff);
      wr_reg(ra(t, 2), 16'h0000);
      wr_reg(ra(t, 0), c);
      cyc(n);
      wr_reg(ra(t, 0), 16'h0000);
      rd_chk(ra(t, 2), e);
   endtask : run_cnt

   task end_sim();
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // Cuts a hang short.
   initial
   begin
      #(10 * 30000);
      num_errors++;
      end_sim();
   end

   // Main sequence.
   initial
   begin
      cyc(12);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++)
         rd_chk(4'(i), (i < 12 && i % 3 == 1) ? 16'hffff : 16'h0000);
      for (int t = 0; t < 4; t++)
      begin
         r = rand_next();
         wr_rd(ra(t, 1), r[15:0]);
         wr_reg(ra(t, 0), r[31:16]);
         rd_chk(ra(t, 0), r[31:16] & (t % 2 ? `PTBC_CTRL_MASK_C : `PTBC_CTRL_MASK_B));
         wr_reg(ra(t, 0), 16'h0000);
      end
      wr_reg(4'hf, 16'hffff);
      rd_chk(4'hf, 16'h0000);
      wr_reg(`PTBC_REG_PRIO, r[15:0]);
      rd_chk(`PTBC_REG_PRIO, {4'h0, r[11:0]});
      for (int t = 0; t < 4; t++)
         for (int c = 1; c < 4; c++)
            run_cnt(t, 16'h8000 | 16'(c << 4), dv[c] * 2 + dv[c] / 2, 16'h0002);
      wr_reg(`PTBC_REG_FLAG, 16'h000f);
      for (int p = 0; p < 2; p++)
      begin
         wr_reg(ra(2 * p + 1, 1), 16'h0003);
         wr_reg(ra(2 * p + 1, 2), 16'h0000);
         wr_reg(`PTBC_REG_ENABLE, 16'h0002 << 2 * p);
         a0 = adc_n[p];
         d0 = dma_n[0];
         d1 = dma_n[1];
         wr_reg(ra(2 * p + 1, 0), 16'h8000);
         cyc(40);
         wr_reg(ra(2 * p + 1, 0), 16'h0000);
         cyc(2);
         `CHK(irq_ff, 4'h2 << 2 * p)
         rd_chk(`PTBC_REG_FLAG, 16'h0002 << 2 * p);
         `CHK(adc_n[p] - a0 inside {[9:11]}, 1'b1)
         `CHK(dma_n[1] - d1, (p == 0) ? adc_n[p] - a0 : 0)
         `CHK(dma_n[0] - d0, 0)
         wr_reg(`PTBC_REG_FLAG, 16'h000f);
         cyc(3);
         `CHK(irq_ff, 4'h0)
      end
      wr_reg(4'h3, 16'h2030);
      wr_reg(4'h1, 16'hffff);
      wr_reg(4'h4, 16'hffff);
      wr_reg(4'h2, 16'hfffe);
      wr_reg(4'h5, 16'h0012);
      wr_reg(`PTBC_REG_ENABLE, 16'h0003);
      wr_reg(4'h0, 16'h8018);
      cyc(27);
      wr_reg(4'h0, 16'h0018);
      rd_chk(4'h2, 16'h0001);
      rd_chk(4'h5, 16'h0013);
      wr_reg(4'h4, 16'h0000);
      wr_reg(4'h1, 16'h0003);
      wr_reg(4'h5, 16'h0000);
      wr_reg(4'h2, 16'h0000);
      wr_reg(4'h0, 16'h8008);
      cyc(30);
      wr_reg(4'h0, 16'h0008);
      cyc(2);
      `CHK(irq_ff, 4'h2)
      rd_chk(`PTBC_REG_FLAG, 16'h0002);
      wr_reg(`PTBC_REG_FLAG, 16'h000f);
      idle_mode <= 1'b1;
      wr_reg(4'h2, 16'h0000);
      wr_reg(4'h0, 16'h8018);
      cyc(60);
      wr_reg(4'h0, 16'h0000);
      rd_chk(4'h2, 16'h0000);
      wr_reg(4'h3, 16'h0000);
      wr_reg(`PTBC_REG_ENABLE, 16'h0000);
      run_cnt(2, 16'ha010, 28, 16'h0000);
      run_cnt(3, 16'h8010, 28, 16'h0003);
      idle_mode <= 1'b0;
      for (int t = 0; t < 4; t++)
         for (int m = 0; m < 2; m++)
         begin
            wr_reg(ra(t, 2), 16'h0000);
            wr_reg(ra(t, 1), 16'hffff);
            wr_reg(ra(t, 0), m ? 16'h8040 : 16'h8042);
            if (m)
            begin
               pins[t] <= 1'b1;
               cyc(20);
               pins[t] <= 1'b0;
            end
            else
               repeat (5)
               begin
                  pins[t] <= 1'b1;
                  cyc(4);
                  pins[t] <= 1'b0;
                  cyc(4);
               end
            cyc(8);
            wr_reg(ra(t, 0), 16'h0000);
            rd_chk(ra(t, 2), m ? 16'h0014 : 16'h0005);
            if (m)
               rd_chk(`PTBC_REG_FLAG, 16'h0001 << t);
            wr_reg(`PTBC_REG_FLAG, 16'h000f);
         end
      cyc(4);
      end_sim();
   end
endmodule : testbench

`default_nettype wire
